/* src/alu_flag_defs.svh */
// Constants for the ALU status flag block: register offsets, bit positions,
// reset values and interrupt bits.
// Assumes inclusion by bare name from the package and the design modules.
//
// Overview of operation
// - Fixed overflow when top two result bits differ; sets flag and both stickies.
// - Float overflow when unbiased exponent exceeds 127; sets flag and both stickies.
// - Float underflow too small for output format also sets zero flag.
// - Explicit load of second status word reaches conditions one cycle later, or at once if that element has an ALU result in the same cycle.
// - Second status word bit 31 holds its element's newest compare: one for X greater, zero for Y.
// - Each compare by that element shifts the eight history bits right, newest entering at top.
// - Bits 30 and 29 hold the two previous compares, in increasing age.
// - History spans bits 31 down to 24, oldest at bit 24.
`ifndef ALU_FLAG_DEFS_SVH
`define ALU_FLAG_DEFS_SVH

// Register byte offsets
`define OFS_ARITH_STATUS_PE_X  8'h00
`define OFS_ARITH_STATUS_PE_Y  8'h04
`define OFS_STICKY_STATUS_PE_X 8'h08
`define OFS_STICKY_STATUS_PE_Y 8'h0C
`define OFS_COND_STATUS_PE_Y   8'h10
`define OFS_IRQ_STATUS         8'h14
`define OFS_IRQ_MASK           8'h18

// Arithmetic status bit positions
`define BIT_ZERO               0
`define BIT_OVERFLOW           1
`define BIT_HISTORY_MSB        31
`define BIT_HISTORY_LSB        24

// Sticky status bit positions
`define BIT_FIXED_OVF_STICKY   0
`define BIT_FLOAT_OVF_STICKY   1
`define BIT_FLOAT_UNF_STICKY   2

// Interrupt status bit positions
`define IRQ_FIXED_OVF          0
`define IRQ_FLOAT_OVF          1
`define IRQ_FLOAT_UNF          2
`define IRQ_WIDTH              3

// Float format
`define EXP_BIAS               9'h07F
`define EXP_MAX_UNBIASED       9'h07F

// Reset values
`define RESET_STATUS           32'h0000_0000
`define RESET_STICKY           32'h0000_0000
`define RESET_MASK             3'h0

// AXI responses
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

/* src/alu_flag_eval.sv */
// Flag evaluation for one processing element's ALU result.
// Assumes the result fields are stable and valid in the same cycle.
`timescale 1ns/1ps
`include "alu_flag_defs.svh"

module alu_flag_eval
  import alu_flag_pkg::*;
(
  input  wire alu_result_s result,
  output alu_flags_s       flags
);

  logic       fixed_ovf;
  logic       float_ovf;
  logic       fixed_zero;
  logic [8:0] unbiased;

  always_comb begin
    fixed_ovf  = result.fixed_result[31] ^ result.fixed_result[30];
    unbiased   = {1'b0, result.float_exp} - `EXP_BIAS;
    float_ovf  = (result.float_exp > 8'h00) && !unbiased[8]
                 && (unbiased > `EXP_MAX_UNBIASED);
    fixed_zero = (result.fixed_result == 32'h0000_0000);
    flags.float_unf = result.is_float && result.float_tiny;
    flags.fixed_ovf = !result.is_float && fixed_ovf;
    flags.float_ovf = result.is_float && float_ovf;
    flags.overflow  = flags.fixed_ovf || flags.float_ovf;
    flags.zero      = result.is_float ? (result.float_zero || flags.float_unf)
                                      : fixed_zero;
  end

endmodule : alu_flag_eval

/* src/alu_flag_pkg.sv */
// Types for the ALU status flag block.
// Assumes alu_flag_defs.svh is on the include path.
`include "alu_flag_defs.svh"

package alu_flag_pkg;

  // One ALU result from one processing element
  typedef struct packed {
    logic        valid;
    logic        is_float;
    logic        is_compare;
    logic        x_greater;
    logic [31:0] fixed_result;
    logic [7:0]  float_exp;
    logic        float_zero;
    logic        float_tiny;
  } alu_result_s;

  // Flags produced for one result
  typedef struct packed {
    logic zero;
    logic overflow;
    logic fixed_ovf;
    logic float_ovf;
    logic float_unf;
  } alu_flags_s;

  // Instruction load port for a status register
  typedef struct packed {
    logic        load_x;
    logic        load_y;
    logic [31:0] data;
  } status_load_s;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_e;

endpackage : alu_flag_pkg

/* src/alu_status_flag_logic.sv */
// ALU status flag logic for two processing elements with AXI4-Lite access.
// Assumes ALU results arrive as one-cycle valid strokes on sys_clk.
`timescale 1ns/1ps
`include "alu_flag_defs.svh"

module alu_status_flag_logic
  import alu_flag_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire alu_result_s result_pe_x,
  input  wire alu_result_s result_pe_y,
  input  wire status_load_s status_load,
  output logic [31:0]      arith_status_pe_x,
  output logic [31:0]      arith_status_pe_y,
  output logic [31:0]      cond_status_pe_y,
  output logic [31:0]      sticky_status_pe_x,
  output logic [31:0]      sticky_status_pe_y,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************************************
  // Flag evaluation
  // ****************************************************************
  alu_flags_s flags_x;
  alu_flags_s flags_y;

  alu_flag_eval u_eval_x (
    .result (result_pe_x),
    .flags  (flags_x)
  );

  alu_flag_eval u_eval_y (
    .result (result_pe_y),
    .flags  (flags_y)
  );

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [31:0] wr_mask;
  logic        wr_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_mask       = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_comb begin
    case (aw_addr)
      `OFS_ARITH_STATUS_PE_X,
      `OFS_ARITH_STATUS_PE_Y,
      `OFS_STICKY_STATUS_PE_X,
      `OFS_STICKY_STATUS_PE_Y,
      `OFS_IRQ_MASK:          wr_ok = 1'b1;
      default:                wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Bus write strobes decoded from the held write address
  logic        bus_wr_x;
  logic        bus_wr_y;
  logic        bus_wr_sx;
  logic        bus_wr_sy;
  logic        bus_wr_mask;

  assign bus_wr_x    = wr_fire && (aw_addr == `OFS_ARITH_STATUS_PE_X);
  assign bus_wr_y    = wr_fire && (aw_addr == `OFS_ARITH_STATUS_PE_Y);
  assign bus_wr_sx   = wr_fire && (aw_addr == `OFS_STICKY_STATUS_PE_X);
  assign bus_wr_sy   = wr_fire && (aw_addr == `OFS_STICKY_STATUS_PE_Y);
  assign bus_wr_mask = wr_fire && (aw_addr == `OFS_IRQ_MASK);

  // ****************************************************************
  // Arithmetic status registers
  // ****************************************************************
  function automatic logic [31:0] apply_flags(input logic [31:0] cur,
                                              input alu_flags_s f);
    logic [31:0] v;
    v = cur;
    v[`BIT_OVERFLOW] = f.overflow;
    v[`BIT_ZERO]     = f.zero;
    return v;
  endfunction : apply_flags

  logic [31:0] next_status_x;
  logic [31:0] next_status_y;

  always_comb begin
    next_status_x = arith_status_pe_x;
    if (status_load.load_x)
      next_status_x = status_load.data;
    else if (bus_wr_x)
      next_status_x = (arith_status_pe_x & ~wr_mask) | (w_data & wr_mask);
    if (result_pe_x.valid)
      next_status_x = apply_flags(next_status_x, flags_x);
  end

  always_comb begin
    next_status_y = arith_status_pe_y;
    if (status_load.load_y)
      next_status_y = status_load.data;
    else if (bus_wr_y)
      next_status_y = (arith_status_pe_y & ~wr_mask) | (w_data & wr_mask);
    if (result_pe_y.valid) begin
      next_status_y = apply_flags(next_status_y, flags_y);
      if (result_pe_y.is_compare)
        next_status_y[`BIT_HISTORY_MSB:`BIT_HISTORY_LSB] =
          {result_pe_y.x_greater,
           next_status_y[`BIT_HISTORY_MSB:`BIT_HISTORY_LSB+1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      arith_status_pe_x <= `RESET_STATUS;
    else
      arith_status_pe_x <= next_status_x;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      arith_status_pe_y <= `RESET_STATUS;
    else
      arith_status_pe_y <= next_status_y;
  end

  // Conditions see ALU updates at once, explicit loads one cycle late unless an ALU update comes with them
  always_ff @(posedge sys_clk) begin
    if (!resetn)
      cond_status_pe_y <= `RESET_STATUS;
    else if (!(status_load.load_y || bus_wr_y) || result_pe_y.valid)
      cond_status_pe_y <= next_status_y;
  end

  // ****************************************************************
  // Sticky registers, shared by both elements
  // ****************************************************************
  logic fixed_ovf_any;
  logic float_ovf_any;
  logic float_unf_any;

  assign fixed_ovf_any = (result_pe_x.valid && flags_x.fixed_ovf)
                         || (result_pe_y.valid && flags_y.fixed_ovf);
  assign float_ovf_any = (result_pe_x.valid && flags_x.float_ovf)
                         || (result_pe_y.valid && flags_y.float_ovf);
  assign float_unf_any = (result_pe_x.valid && flags_x.float_unf)
                         || (result_pe_y.valid && flags_y.float_unf);

  function automatic logic [31:0] set_sticky(input logic [31:0] cur);
    logic [31:0] v;
    v = cur;
    v[`BIT_FIXED_OVF_STICKY] = v[`BIT_FIXED_OVF_STICKY] | fixed_ovf_any;
    v[`BIT_FLOAT_OVF_STICKY] = v[`BIT_FLOAT_OVF_STICKY] | float_ovf_any;
    v[`BIT_FLOAT_UNF_STICKY] = v[`BIT_FLOAT_UNF_STICKY] | float_unf_any;
    return v;
  endfunction : set_sticky

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      sticky_status_pe_x <= `RESET_STICKY;
    else if (bus_wr_sx)
      sticky_status_pe_x <= set_sticky((sticky_status_pe_x & ~wr_mask) | (w_data & wr_mask));
    else
      sticky_status_pe_x <= set_sticky(sticky_status_pe_x);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      sticky_status_pe_y <= `RESET_STICKY;
    else if (bus_wr_sy)
      sticky_status_pe_y <= set_sticky((sticky_status_pe_y & ~wr_mask) | (w_data & wr_mask));
    else
      sticky_status_pe_y <= set_sticky(sticky_status_pe_y);
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic                  rd_irq_status;

  assign irq_events = {float_unf_any, float_ovf_any, fixed_ovf_any};

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      irq_status <= '0;
    else if (rd_irq_status)
      irq_status <= irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      irq_mask <= `RESET_MASK;
    else if (bus_wr_mask && w_strb[0])
      irq_mask <= w_data[`IRQ_WIDTH-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic [31:0] rd_value;
  logic        rd_ok;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_irq_status = s_axi_arvalid && s_axi_arready
                         && (s_axi_araddr == `OFS_IRQ_STATUS);

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_ARITH_STATUS_PE_X:  rd_value = arith_status_pe_x;
      `OFS_ARITH_STATUS_PE_Y:  rd_value = arith_status_pe_y;
      `OFS_STICKY_STATUS_PE_X: rd_value = sticky_status_pe_x;
      `OFS_STICKY_STATUS_PE_Y: rd_value = sticky_status_pe_y;
      `OFS_COND_STATUS_PE_Y:   rd_value = cond_status_pe_y;
      `OFS_IRQ_STATUS:         rd_value = {29'h0000_0000, irq_status};
      `OFS_IRQ_MASK:           rd_value = {29'h0000_0000, irq_mask};
      default: begin
        rd_value = 32'h0000_0000;
        rd_ok    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : alu_status_flag_logic

/* tb/alu_flag_properties.sv */
// Concurrent checks on the ALU status flag block.
// Bound to alu_status_flag_logic; sees its ports only.
`timescale 1ns/1ps
module alu_flag_checker
  import alu_flag_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire alu_result_s  result_pe_x,
  input  wire alu_result_s  result_pe_y,
  input  wire status_load_s status_load,
  input  wire logic [31:0]  arith_status_pe_x,
  input  wire logic [31:0]  arith_status_pe_y,
  input  wire logic [31:0]  cond_status_pe_y,
  input  wire logic [31:0]  sticky_status_pe_x,
  input  wire logic [31:0]  sticky_status_pe_y
);
  // ****
  // Helpers
  // ****
  logic fix_x;
  logic fix_y;
  logic flt_x;
  assign fix_x = result_pe_x.valid && !result_pe_x.is_float;
  assign fix_y = result_pe_y.valid && !result_pe_y.is_float;
  assign flt_x = result_pe_x.valid && result_pe_x.is_float;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence load_y_alone;
    status_load.load_y && !result_pe_y.valid;
  endsequence
  sequence y_quiet;
    !status_load.load_y && !result_pe_y.valid;
  endsequence
  // ****
  // Properties
  // ****
  fixed_ovf_x_a: assert property (
    fix_x && (result_pe_x.fixed_result[31] ^ result_pe_x.fixed_result[30])
    |=> arith_status_pe_x[1] && sticky_status_pe_x[0] && sticky_status_pe_y[0])
    else $error("fixed overflow not flagged on x");
  ovf_clear_x_a: assert property (
    fix_x && !result_pe_x.is_compare
    && !(result_pe_x.fixed_result[31] ^ result_pe_x.fixed_result[30])
    |=> !arith_status_pe_x[1])
    else $error("overflow flag not cleared on x");
  zero_fixed_x_a: assert property (
    fix_x && !result_pe_x.is_compare
    |=> arith_status_pe_x[0] == ($past(result_pe_x.fixed_result) == 32'h0000_0000))
    else $error("zero flag wrong on x");
  float_ovf_x_a: assert property (
    flt_x && !result_pe_x.float_tiny
    |=> arith_status_pe_x[1] == ($past(result_pe_x.float_exp) == 8'hFF))
    else $error("float overflow flag wrong on x");
  float_ovf_sticky_a: assert property (
    flt_x && result_pe_x.float_exp == 8'hFF
    |=> sticky_status_pe_x[1] && sticky_status_pe_y[1])
    else $error("float overflow sticky not set");
  underflow_zero_a: assert property (
    flt_x && result_pe_x.float_tiny |=> arith_status_pe_x[0] && sticky_status_pe_y[2])
    else $error("underflow did not set zero flag");
  load_seen_a: assert property (
    load_y_alone |=> arith_status_pe_y == $past(status_load.data))
    else $error("status load not stored");
  cond_delay_a: assert property (
    load_y_alone ##1 y_quiet |=> cond_status_pe_y == $past(status_load.data, 2))
    else $error("conditional view not updated after extra cycle");
  cond_hold_a: assert property (
    load_y_alone |=> $stable(cond_status_pe_y))
    else $error("conditional view took explicit load too early");
  history_shift_a: assert property (
    result_pe_y.valid && result_pe_y.is_compare
    |=> arith_status_pe_y[31:24]
        == {$past(result_pe_y.x_greater), $past(arith_status_pe_y[31:25])})
    else $error("compare history shift wrong");
  ovf_y_a: assert property (
    fix_y && (result_pe_y.fixed_result[31] ^ result_pe_y.fixed_result[30])
    |=> arith_status_pe_y[1] && sticky_status_pe_x[0])
    else $error("fixed overflow not flagged on y");
endmodule : alu_flag_checker

bind alu_status_flag_logic alu_flag_checker i_alu_flag_checker (
  .sys_clk(sys_clk), .resetn(resetn), .result_pe_x(result_pe_x),
  .result_pe_y(result_pe_y), .status_load(status_load),
  .arith_status_pe_x(arith_status_pe_x), .arith_status_pe_y(arith_status_pe_y),
  .cond_status_pe_y(cond_status_pe_y), .sticky_status_pe_x(sticky_status_pe_x),
  .sticky_status_pe_y(sticky_status_pe_y));

/* tb/testbench.sv */
// Self-checking bench for the ALU status flag block.
// Drives ALU results, status loads and AXI4-Lite at sys_clk edges.
`timescale 1ns/1ps
module testbench
  import alu_flag_pkg::*;
;
  logic sys_clk = 0, resetn = 0, irq;
  alu_result_s res_x = '0, res_y = '0;
  status_load_s ld = '0;
  logic [31:0] ax, ay, cy, sx, sy, wdata = 0, rdata, rd;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  int failures = 0, compares = 0;
  always #4 sys_clk = ~sys_clk;
  alu_status_flag_logic i_alu_status_flag_logic (
    .sys_clk(sys_clk), .resetn(resetn), .result_pe_x(res_x), .result_pe_y(res_y),
    .status_load(ld), .arith_status_pe_x(ax), .arith_status_pe_y(ay),
    .cond_status_pe_y(cy), .sticky_status_pe_x(sx), .sticky_status_pe_y(sy),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ****
  // Shared tasks
  // ****
  task end_of_test;
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function alu_result_s mk(logic [31:0] v, logic [7:0] e, logic [3:0] k);
    mk = '0;
    mk.valid = 1'b1;
    mk.fixed_result = v;
    mk.float_exp = e;
    {mk.is_float, mk.is_compare, mk.x_greater, mk.float_tiny} = k;
  endfunction : mk
  task alu(input alu_result_s r, input logic y);
    @(posedge sys_clk);
    if (y) res_y <= r;
    else res_x <= r;
    @(posedge sys_clk);
    res_x <= '0;
    res_y <= '0;
    #1;
  endtask : alu
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_on, w_on;
    @(posedge sys_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    {aw_on, w_on, rs} = 4'hF;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (aw_on && awready) {awvalid, aw_on} <= 2'b00;
      if (w_on && wready) {wvalid, w_on} <= 2'b00;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) failures++;
  endtask : axw
  task axr(input logic [7:0] a);
    int n;
    logic ar_on;
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    ar_on = 1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (ar_on && arready) {arvalid, ar_on} <= 2'b00;
      if (rvalid) begin
        {rd, rs} = {rdata, rresp};
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) failures++;
  endtask : axr
  // ****
  // Scenarios
  // ****
  task t_regs;
    for (int a = 0; a <= 24; a += 4) begin
      axr(a[7:0]);
      chk("reset word", 0, rd);
    end
    axr(8'h1C);
    chk("unmapped resp", 2'h2, rs);
    axw(8'h10, 32'h0000_0003);
    chk("read-only resp", 2'h2, rs);
    axw(8'h00, 32'h0000_0003);
    axr(8'h00);
    chk("status x rw", 3, rd);
  endtask : t_regs
  task t_irq;
    alu(mk(32'h4000_0000, 0, 0), 0);
    chk("ovf x", 2, ax[1:0]);
    chk("sticky x", 1, sx[0]);
    chk("sticky y", 1, sy[0]);
    chk("irq masked", 0, irq);
    axw(8'h18, 32'h0000_0007);
    #1 chk("irq up", 1, irq);
    axr(8'h14);
    chk("irq status", 1, rd[2:0]);
    #1 chk("irq cleared", 0, irq);
  endtask : t_irq
  task t_fixed;
    logic [31:0] v [6] = '{0, 32'h8000_0000, 32'hC000_0000, 32'h3FFF_FFFF,
                           32'h4000_0000, 5};
    for (int i = 0; i <= 6; i++) begin
      @(posedge sys_clk);
      res_x <= (i < 6) ? mk(v[i], 0, 0) : '0;
      #1;
      if (i > 0) chk("fixed flags", {v[i-1][31] ^ v[i-1][30], v[i-1] == 0}, ax[1:0]);
    end
  endtask : t_fixed
  task t_float;
    alu_result_s r;
    r = mk(0, 8'h10, 4'h8);
    r.float_zero = 1'b1;
    alu(r, 0);
    chk("float zero", 1, ax[1:0]);
    alu(mk(0, 8'hFF, 4'h8), 0);
    chk("float ovf", 2, ax[1:0]);
    chk("float sticky", 3, {sx[1], sy[1]});
    alu(mk(0, 8'hFE, 4'h8), 0);
    chk("float no ovf", 0, ax[1:0]);
    alu(mk(0, 8'h00, 4'h9), 0);
    chk("underflow zero", 1, ax[1:0]);
    chk("underflow sticky", 1, sy[2]);
    axw(8'h08, 32'h0000_0000);
    chk("sticky x write", 0, sx);
  endtask : t_float
  task t_load(input logic [31:0] d);
    @(posedge sys_clk);
    ld <= '{1'b0, 1'b1, d};
    @(posedge sys_clk);
    ld <= '0;
    #1 chk("load seen", d, ay);
  endtask : t_load
  task t_pipe;
    t_load(0);
    repeat (2) @(posedge sys_clk);
    t_load(32'hA5C3_0F00);
    chk("cond early", 0, cy);
    @(posedge sys_clk);
    #1 chk("cond late", 32'hA5C3_0F00, cy);
    alu(mk(1, 0, 0), 0);
    alu(mk(32'h8000_0000, 0, 0), 1);
    chk("y ovf own", 2, ay[1:0]);
    chk("x untouched", 0, ax[1:0]);
    @(posedge sys_clk);
    ld <= '{1'b1, 1'b0, 32'h0000_0001};
    @(posedge sys_clk);
    ld <= '0;
    #1 chk("load x", 1, ax);
  endtask : t_pipe
  task t_hist;
    logic [8:0] g = 9'b1_1011_0010;
    logic [7:0] h = 0;
    t_load(0);
    for (int i = 0; i < 9; i++) begin
      alu(mk(1, 0, {2'b01, g[i], 1'b0}), 1);
      h = {g[i], h[7:1]};
      chk("history", h, ay[31:24]);
    end
    axr(8'h04);
    chk("history word", h, rd[31:24]);
  endtask : t_hist
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_irq();
    t_fixed();
    t_float();
    t_pipe();
    t_hist();
    end_of_test();
  end
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule : testbench
